/* File: debug_status_capture.sv */
// Overview of operation
// - the status register is special purpose register 0x130, reachable only in supervisor state, read and cleared.
// - bit 0 is set by a debug event while debug interrupts are disabled and not by one while they are enabled.
// - for synchronous events in internal debug mode bit 0 tells whether the debug interrupt is imprecise.
// - bits 2:3 hold the last reset type, 00 none since cleared, 01 core, 10 chip, 11 system.
// - every processor reset loads bits 2:3 with the code of that reset whatever they held.
// - bit 4 is set by an instruction completion event and reads 0 if none happened.
// - bit 5 is set by a taken branch event and reads 0 otherwise.
// - bit 12 is set when the first data watch matches a read.
// - bit 13 is set when the first data watch matches a write.
// - bit 14 is set when the second data watch matches a read.
// - bit 15 is set when the second data watch matches a write.
// - bit 30 shows whether the watch 1/2 range is reversed by auto-toggle.
// - bit 31 shows whether the watch 3/4 range is reversed by auto-toggle.
// - with the watch 3/4 toggle enable set, its range mode may reverse and bit 31 reports it.
module debug_status_capture (
    // clock and reset
    input  wire  logic                                 mclk,
    input  wire  logic                                 reset,
    input  wire  logic [1:0]                           reset_kind,
    // special purpose register port
    input  wire  logic                                 spr_rd,
    input  wire  logic                                 spr_wr,
    input  wire  logic [debug_status_pkg::SPR_W-1:0]   spr_num,
    input  wire  logic [0:debug_status_pkg::DATA_W-1]  spr_wdata,
    input  wire  logic                                 supervisor,
    output logic [0:debug_status_pkg::DATA_W-1]        spr_rdata,
    output logic                                       spr_ack,
    output logic                                       spr_priv_fault,
    // debug events
    input  wire  logic                                 debug_interrupt_enable,
    input  wire  logic                                 unconditional_event,
    input  wire  logic                                 instr_complete_event,
    input  wire  logic                                 taken_branch_event,
    input  wire  logic                                 interrupt_event,
    input  wire  logic                                 trap_event,
    input  wire  logic [debug_status_pkg::NUM_INSTR_WATCH-1:0] instr_watch_event,
    input  wire  logic                                 data_watch1_read_event,
    input  wire  logic                                 data_watch1_write_event,
    input  wire  logic                                 data_watch2_read_event,
    input  wire  logic                                 data_watch2_write_event,
    input  wire  logic                                 handler_exit_event,
    // instruction watch range auto-toggle
    input  wire  logic                                 instr_watch12_toggle_enable,
    input  wire  logic                                 instr_watch34_toggle_enable,
    input  wire  logic [1:0]                           instr_watch12_range_mode,
    input  wire  logic [1:0]                           instr_watch34_range_mode,
    input  wire  logic                                 instr_watch12_toggle_event,
    input  wire  logic                                 instr_watch34_toggle_event,
    output logic [1:0]                                 instr_watch12_effective_mode,
    output logic [1:0]                                 instr_watch34_effective_mode,
    // status view for the debug logic
    output logic [0:debug_status_pkg::DATA_W-1]        debug_event_status,
    output logic [0:debug_status_pkg::DATA_W-1]        debug_data_word
);
    import debug_status_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [0:DATA_W-1] flags_ff;
    logic [0:DATA_W-1] nxt_flags;
    logic [0:DATA_W-1] data_word_ff;
    logic [0:DATA_W-1] nxt_data_word;
    logic [0:DATA_W-1] rdata_ff;
    logic [0:DATA_W-1] nxt_rdata;
    logic              ack_ff;
    logic              nxt_ack;
    logic              fault_ff;
    logic              nxt_fault;
    logic              reset_seen_ff;
    logic              nxt_reset_seen;
    logic [0:DATA_W-1] status_word;
    logic [0:DATA_W-1] clear_mask;
    logic [0:DATA_W-1] set_mask;
    logic              any_event;
    logic              hit_status;
    logic              hit_data;
    logic              access;
    logic              toggle12;
    logic              toggle34;
    logic [1:0]        mode12;
    logic [1:0]        mode34;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic spr_match(input logic [SPR_W-1:0] num, input logic [SPR_W-1:0] target);
        spr_match = (num == target);
    endfunction

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    always_comb begin
        hit_status = spr_match(spr_num, SPR_DEBUG_EVENT_STATUS);
        hit_data   = spr_match(spr_num, SPR_DEBUG_DATA_WORD);
        access     = (spr_rd || spr_wr) && (hit_status || hit_data);
        clear_mask = ZERO_WORD;
        // writes from user state clear nothing
        if (spr_wr && hit_status && supervisor) begin
            clear_mask = spr_wdata;
        end
    end

    // ------------------------------------------------------------
    // sticky event flags
    // ------------------------------------------------------------
    always_comb begin
        set_mask = ZERO_WORD;
        set_mask[BIT_UNCONDITIONAL]  = unconditional_event;
        set_mask[BIT_INSTR_COMPLETE] = instr_complete_event;
        set_mask[BIT_TAKEN_BRANCH]   = taken_branch_event;
        set_mask[BIT_INTERRUPT]      = interrupt_event;
        set_mask[BIT_TRAP]           = trap_event;
        for (int i = 0; i < NUM_INSTR_WATCH; i++) begin
            set_mask[BIT_INSTR_WATCH1 + i] = instr_watch_event[i];
        end
        set_mask[BIT_DATA1_READ]     = data_watch1_read_event;
        set_mask[BIT_DATA1_WRITE]    = data_watch1_write_event;
        set_mask[BIT_DATA2_READ]     = data_watch2_read_event;
        set_mask[BIT_DATA2_WRITE]    = data_watch2_write_event;
        set_mask[BIT_HANDLER_EXIT]   = handler_exit_event;
        any_event = |set_mask;
        // an event with debug interrupts disabled is reported imprecise
        set_mask[BIT_IMPRECISE] = any_event && !debug_interrupt_enable;

        // set wins over a clear in the same cycle
        nxt_flags = (flags_ff & ~clear_mask) | set_mask;
        nxt_flags[BIT_RESET_TYPE_HI] = flags_ff[BIT_RESET_TYPE_HI] & ~clear_mask[BIT_RESET_TYPE_HI];
        nxt_flags[BIT_RESET_TYPE_LO] = flags_ff[BIT_RESET_TYPE_LO] & ~clear_mask[BIT_RESET_TYPE_LO];
        nxt_reset_seen = 1'b1;
        // first edge after release loads the reset type over any clear
        if (!reset_seen_ff) begin
            nxt_flags[BIT_RESET_TYPE_HI] = reset_kind[1];
            nxt_flags[BIT_RESET_TYPE_LO] = reset_kind[0];
        end
        // reserved bits never hold a value
        nxt_flags[BIT_HANDLER_EXIT+1:BIT_WATCH12_TOGGLE-1] = '0;
        // the toggle bits live in the trackers
        nxt_flags[BIT_WATCH12_TOGGLE] = 1'b0;
        nxt_flags[BIT_WATCH34_TOGGLE] = 1'b0;
    end

    // ------------------------------------------------------------
    // read data, data word and answers
    // ------------------------------------------------------------
    always_comb begin
        status_word = flags_ff;
        status_word[BIT_WATCH12_TOGGLE] = toggle12;
        status_word[BIT_WATCH34_TOGGLE] = toggle34;
        nxt_data_word = data_word_ff;
        if (spr_wr && hit_data && supervisor) begin
            nxt_data_word = spr_wdata;
        end
        // reads return the word as it stood before this edge
        nxt_rdata = ZERO_WORD;
        if (spr_rd && supervisor && hit_status) begin
            nxt_rdata = status_word;
        end else if (spr_rd && supervisor && hit_data) begin
            nxt_rdata = data_word_ff;
        end
        nxt_ack   = access && supervisor;
        nxt_fault = access && !supervisor;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags_ff      <= ZERO_WORD;
            data_word_ff  <= ZERO_WORD;
            rdata_ff      <= ZERO_WORD;
            ack_ff        <= 1'b0;
            fault_ff      <= 1'b0;
            reset_seen_ff <= 1'b0;
        end else begin
            flags_ff      <= nxt_flags;
            data_word_ff  <= nxt_data_word;
            rdata_ff      <= nxt_rdata;
            ack_ff        <= nxt_ack;
            fault_ff      <= nxt_fault;
            reset_seen_ff <= nxt_reset_seen;
        end
    end

    // ------------------------------------------------------------
    // auto-toggle trackers
    // ------------------------------------------------------------
    range_toggle_tracker u_watch12 (
        .mclk           (mclk),
        .reset          (reset),
        .toggle_enable  (instr_watch12_toggle_enable),
        .range_mode     (instr_watch12_range_mode),
        .toggle_event   (instr_watch12_toggle_event),
        .clear          (clear_mask[BIT_WATCH12_TOGGLE]),
        .toggle_state   (toggle12),
        .effective_mode (mode12)
    );

    range_toggle_tracker u_watch34 (
        .mclk           (mclk),
        .reset          (reset),
        .toggle_enable  (instr_watch34_toggle_enable),
        .range_mode     (instr_watch34_range_mode),
        .toggle_event   (instr_watch34_toggle_event),
        .clear          (clear_mask[BIT_WATCH34_TOGGLE]),
        .toggle_state   (toggle34),
        .effective_mode (mode34)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign spr_rdata                    = rdata_ff;
    assign spr_ack                      = ack_ff;
    assign spr_priv_fault               = fault_ff;
    assign debug_event_status           = status_word;
    assign debug_data_word              = data_word_ff;
    assign instr_watch12_effective_mode = mode12;
    assign instr_watch34_effective_mode = mode34;

endmodule

/* File: debug_status_pkg.sv */
package debug_status_pkg;

    // ------------------------------------------------------------
    // special purpose register numbers
    // ------------------------------------------------------------
    localparam int          SPR_W                  = 10;
    localparam int          DATA_W                 = 32;
    localparam logic [9:0]  SPR_DEBUG_EVENT_STATUS = 10'h130;
    localparam logic [9:0]  SPR_DEBUG_DATA_WORD    = 10'h3f3;

    // ------------------------------------------------------------
    // status field positions (bit 0 is the most significant bit)
    // ------------------------------------------------------------
    localparam int BIT_IMPRECISE      = 0;
    localparam int BIT_UNCONDITIONAL  = 1;
    localparam int BIT_RESET_TYPE_HI  = 2;
    localparam int BIT_RESET_TYPE_LO  = 3;
    localparam int BIT_INSTR_COMPLETE = 4;
    localparam int BIT_TAKEN_BRANCH   = 5;
    localparam int BIT_INTERRUPT      = 6;
    localparam int BIT_TRAP           = 7;
    localparam int BIT_INSTR_WATCH1   = 8;
    localparam int BIT_DATA1_READ     = 12;
    localparam int BIT_DATA1_WRITE    = 13;
    localparam int BIT_DATA2_READ     = 14;
    localparam int BIT_DATA2_WRITE    = 15;
    localparam int BIT_HANDLER_EXIT   = 16;
    localparam int BIT_WATCH12_TOGGLE = 30;
    localparam int BIT_WATCH34_TOGGLE = 31;
    localparam int NUM_INSTR_WATCH    = 4;

    // ------------------------------------------------------------
    // reset type codes and range modes
    // ------------------------------------------------------------
    localparam logic [1:0] RESET_NONE   = 2'h0;
    localparam logic [1:0] RESET_CORE   = 2'h1;
    localparam logic [1:0] RESET_CHIP   = 2'h2;
    localparam logic [1:0] RESET_SYSTEM = 2'h3;

    localparam logic [1:0] RANGE_INCLUSIVE = 2'h2;
    localparam logic [1:0] RANGE_EXCLUSIVE = 2'h3;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

/* File: range_toggle_tracker.sv */
module range_toggle_tracker (
    // clock and reset
    input  wire  logic       mclk,
    input  wire  logic       reset,
    // configuration
    input  wire  logic       toggle_enable,
    input  wire  logic [1:0] range_mode,
    // events
    input  wire  logic       toggle_event,
    input  wire  logic       clear,
    // state
    output logic             toggle_state,
    output logic [1:0]       effective_mode
);
    import debug_status_pkg::*;

    logic       toggle_ff;
    logic       nxt_toggle;
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;

    // ------------------------------------------------------------
    // toggle state and effective range mode
    // ------------------------------------------------------------
    always_comb begin
        nxt_toggle = toggle_ff;
        if (clear) begin
            nxt_toggle = 1'b0;
        end
        // a toggle in the clearing cycle still flips the range
        if (toggle_event && toggle_enable) begin
            nxt_toggle = ~toggle_ff;
        end
        nxt_mode = range_mode;
        if (nxt_toggle && (range_mode == RANGE_INCLUSIVE)) begin
            nxt_mode = RANGE_EXCLUSIVE;
        end else if (nxt_toggle && (range_mode == RANGE_EXCLUSIVE)) begin
            nxt_mode = RANGE_INCLUSIVE;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            toggle_ff <= 1'b0;
            mode_ff   <= RESET_NONE;
        end else begin
            toggle_ff <= nxt_toggle;
            mode_ff   <= nxt_mode;
        end
    end

    assign toggle_state   = toggle_ff;
    assign effective_mode = mode_ff;

endmodule

/* File: debug_status_chk.sv */
module debug_status_chk (
    // clock and reset
    input wire logic                                mclk,
    input wire logic                                reset,
    input wire logic [1:0]                          reset_kind,
    // register port
    input wire logic                                spr_rd,
    input wire logic                                spr_wr,
    input wire logic [debug_status_pkg::SPR_W-1:0]  spr_num,
    input wire logic [0:debug_status_pkg::DATA_W-1] spr_wdata,
    input wire logic                                supervisor,
    input wire logic [0:debug_status_pkg::DATA_W-1] spr_rdata,
    input wire logic                                spr_ack,
    input wire logic                                spr_priv_fault,
    // events and status
    input wire logic                                debug_interrupt_enable,
    input wire logic                                instr_complete_event,
    input wire logic                                taken_branch_event,
    input wire logic                                data_watch1_read_event,
    input wire logic                                instr_watch34_toggle_enable,
    input wire logic                                instr_watch34_toggle_event,
    input wire logic [0:debug_status_pkg::DATA_W-1] debug_event_status
);
    import debug_status_pkg::*;
    logic hit;
    assign hit = (spr_rd || spr_wr) && spr_num == SPR_DEBUG_EVENT_STATUS;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // access and flags
    // ------------------------------------------------------------
    a_access_acked: assert property (hit && supervisor |=> spr_ack && !spr_priv_fault)
        else $error("supervisor access not acknowledged");
    a_user_refused: assert property (hit && !supervisor |=> spr_priv_fault && !spr_ack && spr_rdata == ZERO_WORD)
        else $error("user access not refused");
    a_read_value: assert property (hit && spr_rd && supervisor |=> spr_rdata == $past(debug_event_status))
        else $error("read data differs from status");
    a_reset_loads: assert property ($past(reset) && !reset |=> debug_event_status[2:3] == $past(reset_kind))
        else $error("reset type not loaded");
    a_imprecise_sets: assert property (taken_branch_event && !debug_interrupt_enable |=> debug_event_status[0])
        else $error("imprecise flag not set");
    a_branch_sets: assert property (taken_branch_event |=> debug_event_status[5])
        else $error("branch flag not set");
    a_complete_sets: assert property (instr_complete_event |=> debug_event_status[4])
        else $error("completion flag not set");
    a_data_read_sets: assert property (data_watch1_read_event |=> debug_event_status[12])
        else $error("data read flag not set");
    a_reserved_zero: assert property (debug_event_status[17:29] == 13'h0)
        else $error("reserved bits not zero");
    a_clear_one: assert property (hit && spr_wr && supervisor && spr_wdata[5] && !taken_branch_event
        |=> !debug_event_status[5])
        else $error("written one did not clear");
    a_flag_sticky: assert property (debug_event_status[5] && !(hit && spr_wr && supervisor && spr_wdata[5])
        |=> debug_event_status[5])
        else $error("flag lost without clear");
    a_toggle_flips: assert property (instr_watch34_toggle_enable && instr_watch34_toggle_event && !spr_wr
        |=> debug_event_status[31] != $past(debug_event_status[31]))
        else $error("toggle state did not flip");
    c_user: cover property (hit && !supervisor);
    c_imprecise: cover property (taken_branch_event && !debug_interrupt_enable);
    c_toggle: cover property (instr_watch34_toggle_enable && instr_watch34_toggle_event);
endmodule

bind debug_status_capture debug_status_chk i_debug_status_chk (.mclk, .reset, .reset_kind, .spr_rd, .spr_wr,
    .spr_num, .spr_wdata, .supervisor, .spr_rdata, .spr_ack, .spr_priv_fault, .debug_interrupt_enable,
    .instr_complete_event, .taken_branch_event, .data_watch1_read_event, .instr_watch34_toggle_enable,
    .instr_watch34_toggle_event, .debug_event_status);

/* File: tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import debug_status_pkg::*;
    logic        mclk = 1'h0;
    logic        reset = 1'h1;
    logic [1:0]  reset_kind = 2'h1;
    logic        spr_rd = 1'h0;
    logic        spr_wr = 1'h0;
    logic [9:0]  spr_num = 10'h0;
    logic [0:31] spr_wdata = 32'h0;
    logic        supervisor = 1'h1;
    logic        debug_interrupt_enable = 1'h1;
    logic [0:31] ev = 32'h0;
    logic [1:0]  tg_en = 2'h0;
    logic [1:0]  tg_ev = 2'h0;
    logic [1:0]  mode12 = 2'h0;
    logic [1:0]  mode34 = 2'h0;
    logic [0:31] spr_rdata, debug_event_status, debug_data_word;
    logic        spr_ack, spr_priv_fault;
    logic [1:0]  eff12, eff34;
    logic [31:0] last_rd;
    logic        last_ack, last_flt;
    int          bad_count = 0;
    int          n_checks = 0;
    always #50 mclk = ~mclk;
    debug_status_capture i_debug_status_capture (.mclk, .reset, .reset_kind, .spr_rd, .spr_wr, .spr_num,
        .spr_wdata, .supervisor, .spr_rdata, .spr_ack, .spr_priv_fault, .debug_interrupt_enable,
        .unconditional_event(ev[1]), .instr_complete_event(ev[4]), .taken_branch_event(ev[5]),
        .interrupt_event(ev[6]), .trap_event(ev[7]), .instr_watch_event({ev[11], ev[10], ev[9], ev[8]}),
        .data_watch1_read_event(ev[12]), .data_watch1_write_event(ev[13]), .data_watch2_read_event(ev[14]),
        .data_watch2_write_event(ev[15]), .handler_exit_event(ev[16]), .instr_watch12_toggle_enable(tg_en[0]),
        .instr_watch34_toggle_enable(tg_en[1]), .instr_watch12_range_mode(mode12),
        .instr_watch34_range_mode(mode34), .instr_watch12_toggle_event(tg_ev[0]),
        .instr_watch34_toggle_event(tg_ev[1]), .instr_watch12_effective_mode(eff12),
        .instr_watch34_effective_mode(eff34), .debug_event_status, .debug_data_word);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] bw(input int b);
        return 32'h8000_0000 >> b;
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one access; answer captured in its ack cycle, strobes idle one cycle after
    task automatic acc(input logic wr, input logic [9:0] num, input logic [31:0] d, input logic sup);
        spr_rd = !wr;
        spr_wr = wr;
        spr_num = num;
        spr_wdata = d;
        supervisor = sup;
        @(negedge mclk);
        last_rd = spr_rdata;
        last_ack = spr_ack;
        last_flt = spr_priv_fault;
        spr_rd = 1'h0;
        spr_wr = 1'h0;
        @(negedge mclk);
    endtask
    task automatic rd_st;
        acc(1'h0, SPR_DEBUG_EVENT_STATUS, 32'h0, 1'h1);
        chk("ack", 32'h1, 32'(last_ack));
    endtask
    task automatic pulse(input logic [31:0] e);
        ev = e;
        @(negedge mclk);
        ev = 32'h0;
        @(negedge mclk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        @(negedge mclk);
        for (int k = 1; k < 4; k++) begin
            reset = 1'h1;
            reset_kind = 2'(k);
            repeat (6) @(negedge mclk);
            reset = 1'h0;
            @(negedge mclk);
            rd_st();
            chk("reset_type", 32'(k) << 28, last_rd);
            acc(1'h1, SPR_DEBUG_EVENT_STATUS, 32'h3000_0000, 1'h1);
            chk("reset_type_clear", 32'h0, debug_event_status);
        end
    endtask
    task automatic t_events;
        for (int b = 1; b < 17; b++) begin
            if (b != 2 && b != 3) begin
                pulse(bw(b));
                rd_st();
                chk("flag", bw(b), last_rd);
                acc(1'h1, SPR_DEBUG_EVENT_STATUS, ~bw(b), 1'h1);
                chk("zero_write", bw(b), debug_event_status);
                acc(1'h1, SPR_DEBUG_EVENT_STATUS, bw(b), 1'h1);
                chk("one_write", 32'h0, debug_event_status);
            end
        end
    endtask
    task automatic t_refuse;
        debug_interrupt_enable = 1'h0;
        pulse(bw(5));
        debug_interrupt_enable = 1'h1;
        chk("imprecise", bw(0) | bw(5), debug_event_status);
        acc(1'h1, SPR_DEBUG_EVENT_STATUS, 32'hffff_ffff, 1'h0);
        chk("user_fault", 32'h2, 32'({last_flt, last_ack}));
        acc(1'h0, SPR_DEBUG_EVENT_STATUS, 32'h0, 1'h0);
        chk("user_rdata", 32'h0, last_rd);
        chk("user_no_clear", bw(0) | bw(5), debug_event_status);
        acc(1'h1, SPR_DEBUG_EVENT_STATUS, 32'hffff_ffff, 1'h1);
        chk("clear_all", 32'h0, debug_event_status);
    endtask
    task automatic t_dword;
        acc(1'h1, SPR_DEBUG_DATA_WORD, 32'h5a5a_c3c3, 1'h1);
        acc(1'h0, SPR_DEBUG_DATA_WORD, 32'h0, 1'h1);
        chk("data_word", 32'h5a5a_c3c3, last_rd);
        chk("data_word_out", 32'h5a5a_c3c3, debug_data_word);
        acc(1'h0, 10'h131, 32'h0, 1'h1);
        chk("unmapped", 32'h0, {last_rd[31:2], last_flt, last_ack});
    endtask
    task automatic t_toggle;
        mode12 = RANGE_EXCLUSIVE;
        mode34 = RANGE_INCLUSIVE;
        for (int i = 1; i < 3; i++) begin
            tg_en = 2'(i == 1 ? 2 : 3);
            tg_ev = 2'h3;
            @(negedge mclk);
            tg_ev = 2'h0;
            @(negedge mclk);
            chk("toggle_bits", i == 1 ? bw(31) : bw(30), debug_event_status);
            chk("mode34", 32'(i == 1 ? RANGE_EXCLUSIVE : RANGE_INCLUSIVE), 32'(eff34));
            chk("mode12", 32'(i == 1 ? RANGE_EXCLUSIVE : RANGE_INCLUSIVE), 32'(eff12));
        end
        acc(1'h1, SPR_DEBUG_EVENT_STATUS, bw(30), 1'h1);
        chk("toggle_clear", 32'h0, debug_event_status);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        complete_run();
    end
    initial begin
        t_reset();
        t_events();
        t_refuse();
        t_dword();
        t_toggle();
        complete_run();
    end
endmodule
